// *** hw/ccs_pkg.sv ***
package ccs_pkg;
  typedef logic [7:0] ccs_addr_t;
  typedef logic [31:0] ccs_data_t;
  localparam ccs_addr_t OFS_CTRL = 8'h00;
  localparam ccs_addr_t OFS_CALL = 8'h04;
  localparam ccs_addr_t OFS_STAT = 8'h08;
  localparam ccs_addr_t OFS_IRQ_STAT = 8'h0C;
  localparam ccs_addr_t OFS_IRQ_MASK = 8'h10;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;
  // CALL register write fields (pairs: channel 0 low, channel 1 high).
  localparam int CALL_IN_POS = 0;
  localparam int CALL_OUT_POS = 2;
  localparam int CALL_CONN_POS = 4;
  localparam int CALL_END_POS = 6;
  localparam int CALL_KEY_POS = 8;
  // Interrupt status fields.
  localparam int IRQ_OFF_POS = 0;
  localparam int IRQ_ON_POS = 2;
  localparam int IRQ_SIL_POS = 4;
  // Chime stroke, chime gap and lamp flash half period.
  localparam int CLK_KHZ = 25000;
  localparam int STROKE_MS = 500;
  localparam int GAP_MS = 500;
  localparam int FLASH_MS = 500;
  localparam int STROKE_CYC = STROKE_MS * CLK_KHZ;
  localparam int GAP_CYC = GAP_MS * CLK_KHZ;
  localparam int FLASH_CYC = FLASH_MS * CLK_KHZ;
  // Input vector layout and its idle (released, high) reset value.
  localparam int IN_W = 6;
  localparam logic [5:0] IN_RST = 6'h3F;
  typedef enum logic [1:0] {
    SRC_PTT,
    SRC_PANEL,
    SRC_KEY
  } ccs_src_t;
  typedef struct packed {
    ccs_src_t src1;
    ccs_src_t src0;
    logic lamp_flash;
    logic chime_multi;
    logic chime_out_en;
  } ccs_cfg_t;
  typedef struct packed {
    logic inhibit_n;
    logic silence_n;
    logic [1:0] hangup_n;
    logic [1:0] mic_n;
  } ccs_in_t;
endpackage

// *** hw/ccs_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccs_top #(
  parameter int unsigned STROKE_CYC = ccs_pkg::STROKE_CYC,
  parameter int unsigned GAP_CYC = ccs_pkg::GAP_CYC,
  parameter int unsigned FLASH_CYC = ccs_pkg::FLASH_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire ccs_pkg::ccs_addr_t reg_addr_i,
  input wire ccs_pkg::ccs_data_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output ccs_pkg::ccs_data_t reg_rdata_o,
  input wire ccs_pkg::ccs_in_t pins_i,
  output logic [1:0] call_lamp_out_o,
  output logic chime_relay_contact_o,
  output logic irq_o
);
  import ccs_pkg::*;

  typedef enum logic [1:0] {
    CH_IDLE,
    CH_ON,
    CH_GAP
  } ccs_chime_t;

  ccs_cfg_t cfg_ff;
  logic [4:0] mask_ff, irq_ff, nxt_irq;
  ccs_data_t rdata_ff, nxt_rdata;
  logic [IN_W-1:0] sync1_ff, sync2_ff, prev_ff, fall;
  ccs_in_t in_s;
  logic [1:0] hook_ff, nxt_hook, alert_ff, nxt_alert;
  logic [1:0] lamp_ff, off_rise, on_fall;
  logic chime_ff, req_ff, nxt_req, phase_ff;
  logic [23:0] tmr_ff, nxt_tmr, flash_ff;
  ccs_chime_t st_ff, nxt_st;

  // Register decode and call events from software.
  wire wr_ctrl = reg_wr_i && (reg_addr_i == OFS_CTRL);
  wire wr_call = reg_wr_i && (reg_addr_i == OFS_CALL);
  wire wr_istat = reg_wr_i && (reg_addr_i == OFS_IRQ_STAT);
  wire wr_mask = reg_wr_i && (reg_addr_i == OFS_IRQ_MASK);
  wire [1:0] ev_in = wr_call ? reg_wdata_i[CALL_IN_POS+:2] : 2'h0;
  wire [1:0] ev_out = wr_call ? reg_wdata_i[CALL_OUT_POS+:2] : 2'h0;
  wire [1:0] ev_conn = wr_call ? reg_wdata_i[CALL_CONN_POS+:2] : 2'h0;
  wire [1:0] ev_end = wr_call ? reg_wdata_i[CALL_END_POS+:2] : 2'h0;
  wire [1:0] ev_key = wr_call ? reg_wdata_i[CALL_KEY_POS+:2] : 2'h0;
  wire [3:0] src_vec = {cfg_ff.src1, cfg_ff.src0};
  wire inhibit = ~in_s.inhibit_n;
  wire silence = fall[4];
  // Chime starts on any incoming call, and on a connected outgoing
  // call only when enabled; a connect for a channel with no pending
  // call is ignored so the relay never closes with both lamps idle.
  wire chime_set = (|ev_in) | (cfg_ff.chime_out_en & (|(ev_conn & nxt_alert)));
  wire stroke_done = (tmr_ff == 24'h000000);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_ff <= ccs_cfg_t'(CTRL_RST);
      mask_ff <= IRQ_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        cfg_ff <= ccs_cfg_t'(reg_wdata_i[6:0]);
      end
      if (wr_mask) begin
        mask_ff <= reg_wdata_i[4:0];
      end
    end
  end

  // The first stage feeds only the second; edges are taken from the
  // second and third, so each falling edge is seen in exactly one cycle.
  assign in_s = ccs_in_t'(sync2_ff);
  assign fall = prev_ff & ~sync2_ff;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_ff <= IN_RST;
      sync2_ff <= IN_RST;
      prev_ff <= IN_RST;
    end else begin
      sync1_ff <= pins_i;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // Each of the two channels keeps its own hook and alert state.
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      wire [1:0] src = src_vec[2*c+:2];
      wire mic_fall = fall[c];
      wire hang_fall = fall[2+c];
      always_comb begin
        case (src)
          SRC_PTT: begin
            if (mic_fall) begin
              nxt_hook[c] = 1'b1;
            end else if (hang_fall || ev_end[c]) begin
              nxt_hook[c] = 1'b0;
            end else begin
              nxt_hook[c] = hook_ff[c];
            end
          end
          SRC_PANEL: nxt_hook[c] = ~sync2_ff[c];
          SRC_KEY: begin
            if (ev_key[c]) begin
              nxt_hook[c] = 1'b1;
            end else if (ev_end[c]) begin
              nxt_hook[c] = 1'b0;
            end else begin
              nxt_hook[c] = hook_ff[c];
            end
          end
          default: nxt_hook[c] = hook_ff[c];
        endcase
      end
      assign off_rise[c] = nxt_hook[c] & ~hook_ff[c];
      assign on_fall[c] = hook_ff[c] & ~nxt_hook[c];
      // A new call wins over an off-hook or end in the same cycle.
      assign nxt_alert[c] = (ev_in[c] | ev_out[c]) ? 1'b1 :
                            (off_rise[c] | ev_end[c]) ? 1'b0 :
                            alert_ff[c];
    end
  endgenerate

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hook_ff <= 2'h0;
      alert_ff <= 2'h0;
    end else begin
      hook_ff <= nxt_hook;
      alert_ff <= nxt_alert;
    end
  end

  // Lamp flash phase runs freely; lamps are steady unless flashing is set.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flash_ff <= 24'h000000;
      phase_ff <= 1'b0;
    end else if (flash_ff == 24'h000000) begin
      flash_ff <= 24'(FLASH_CYC - 1);
      phase_ff <= ~phase_ff;
    end else begin
      flash_ff <= flash_ff - 24'h000001;
    end
  end

  wire lamp_lit = ~cfg_ff.lamp_flash | phase_ff;
  wire [1:0] nxt_lamp = (inhibit | ~lamp_lit) ? 2'h0 : alert_ff;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lamp_ff <= 2'h0;
    end else begin
      lamp_ff <= nxt_lamp;
    end
  end

  // The chime request drops on silence, when no call alerts any more,
  // or after one stroke in single-stroke mode. A new call wins.
  wire single_end = (st_ff == CH_ON) & stroke_done & ~cfg_ff.chime_multi;
  wire alerting = |nxt_alert;
  assign nxt_req = chime_set ? 1'b1 :
                   (silence | ~alerting | single_end) ? 1'b0 :
                   req_ff;

  always_comb begin
    nxt_st = st_ff;
    nxt_tmr = stroke_done ? 24'h000000 : tmr_ff - 24'h000001;
    case (st_ff)
      CH_IDLE: begin
        if (nxt_req) begin
          nxt_st = CH_ON;
          nxt_tmr = 24'(STROKE_CYC - 1);
        end
      end
      CH_ON: begin
        if (!nxt_req) begin
          nxt_st = CH_IDLE;
        end else if (stroke_done) begin
          nxt_st = CH_GAP;
          nxt_tmr = 24'(GAP_CYC - 1);
        end
      end
      CH_GAP: begin
        if (!nxt_req) begin
          nxt_st = CH_IDLE;
        end else if (stroke_done) begin
          nxt_st = CH_ON;
          nxt_tmr = 24'(STROKE_CYC - 1);
        end
      end
      default: nxt_st = CH_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= CH_IDLE;
      tmr_ff <= 24'h000000;
      req_ff <= 1'b0;
      chime_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      tmr_ff <= nxt_tmr;
      req_ff <= nxt_req;
      chime_ff <= (nxt_st == CH_ON) & ~inhibit;
    end
  end

  // Sticky events; a new event wins over a write-one clear.
  wire [4:0] irq_ev = {silence & req_ff, on_fall, off_rise};
  wire [4:0] irq_clr = wr_istat ? reg_wdata_i[4:0] : 5'h00;
  assign nxt_irq = irq_ev | (irq_ff & ~irq_clr);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_ff <= 5'h00;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  wire [31:0] stat_word = {18'h00000, sync2_ff, req_ff, chime_ff,
                           lamp_ff, alert_ff, hook_ff};

  always_comb begin
    nxt_rdata = 32'h00000000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_CTRL: nxt_rdata = {25'h0000000, cfg_ff};
        OFS_STAT: nxt_rdata = stat_word;
        OFS_IRQ_STAT: nxt_rdata = {27'h0000000, irq_ff};
        OFS_IRQ_MASK: nxt_rdata = {27'h0000000, mask_ff};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign call_lamp_out_o = lamp_ff;
  assign chime_relay_contact_o = chime_ff;
  assign irq_o = |(irq_ff & mask_ff);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  incoming_chime_a: assert property (
    (|ev_in) && pins_i.inhibit_n && $past(pins_i.inhibit_n) && in_s.inhibit_n
    && !fall[4] |-> ##1 req_ff)
    else $error("incoming call did not request the chime");
  outgoing_chime_a: assert property (
    (|ev_conn) && !(|ev_in) && !cfg_ff.chime_out_en |=> !$rose(req_ff))
    else $error("outgoing chime sounded while disabled");
  single_stroke_a: assert property (
    (st_ff == CH_ON) && stroke_done && !cfg_ff.chime_multi && !chime_set
    |=> st_ff == CH_IDLE)
    else $error("single stroke chime repeated");
  lamp_alert_a: assert property (
    call_lamp_out_o[0] |-> $past(alert_ff[0]))
    else $error("lamp lit without a call");
  lamp_steady_a: assert property (
    alert_ff[1] && !cfg_ff.lamp_flash && in_s.inhibit_n |=> call_lamp_out_o[1])
    else $error("steady lamp not lit");
  ptt_offhook_a: assert property (
    fall[0] && src_vec[1:0] == SRC_PTT |=> hook_ff[0])
    else $error("push to talk edge missed");
  panel_follow_a: assert property (
    src_vec[3:2] == SRC_PANEL |=> hook_ff[1] == ~$past(sync2_ff[1]))
    else $error("panel hook does not follow mic input");
  hangup_onhook_a: assert property (
    fall[2] && !fall[0] && src_vec[1:0] == SRC_PTT |=> !hook_ff[0])
    else $error("hang-up edge did not give on-hook");
  silence_stop_a: assert property (
    silence && !chime_set |=> !req_ff && !chime_relay_contact_o)
    else $error("chime not silenced");
  inhibit_block_a: assert property (
    inhibit |=> !chime_relay_contact_o && call_lamp_out_o == 2'h0)
    else $error("alert shown while inhibited");
  edge_once_a: assert property (
    fall[4] |=> !fall[4])
    else $error("falling edge seen twice");
  idle_open_a: assert property (
    alert_ff == 2'h0 |-> !chime_relay_contact_o)
    else $error("chime closed with no call");
  // Per-channel, lamp flash, chime and interrupt checks; antecedents leave out the events that may legally override.
  answer_clear_a: assert property (
    off_rise[1] && !ev_in[1] && !ev_out[1] |=> !alert_ff[1])
    else $error("off-hook left the call alerting");
  in_alert_a: assert property (
    ev_in[0] |=> alert_ff[0])
    else $error("incoming call not alerting");
  out_alert_a: assert property (
    ev_out[1] |=> alert_ff[1])
    else $error("outgoing call not alerting");
  end_lamp_a: assert property (
    ev_end[0] && !ev_in[0] && !ev_out[0] |=> !alert_ff[0] ##1 !call_lamp_out_o[0])
    else $error("lamp still lit after call end");
  ptt_keep_a: assert property (
    hook_ff[0] && src_vec[1:0] == SRC_PTT && !fall[2] && !ev_end[0] |=> hook_ff[0])
    else $error("push to talk off-hook lost");
  hangup_ch1_a: assert property (
    fall[3] && !fall[1] && src_vec[3:2] == SRC_PTT |=> !hook_ff[1])
    else $error("second hang-up edge did not give on-hook");
  key_offhook_a: assert property (
    ev_key[0] && src_vec[1:0] == SRC_KEY |=> hook_ff[0])
    else $error("line key did not give off-hook");
  key_hold_a: assert property (
    src_vec[1:0] == SRC_KEY && !ev_key[0] && !ev_end[0] |=> $stable(hook_ff[0]))
    else $error("line key hook moved without a key or end");
  chan_indep_a: assert property (
    fall[0] && !fall[1] && !fall[3] && !ev_end[1] && src_vec[3:2] == SRC_PTT
    |=> $stable(hook_ff[1]))
    else $error("channel zero edge moved channel one hook");
  flash_dark_a: assert property (
    cfg_ff.lamp_flash && !phase_ff |=> call_lamp_out_o == 2'h0)
    else $error("flashing lamp lit in dark phase");
  out_enabled_a: assert property (
    cfg_ff.chime_out_en && ev_conn[1] && alert_ff[1] && !ev_end[1] && !off_rise[1]
    |=> req_ff)
    else $error("enabled outgoing chime not requested");
  multi_repeat_a: assert property (
    st_ff == CH_ON && stroke_done && cfg_ff.chime_multi && !silence && alerting
    |=> st_ff == CH_GAP)
    else $error("multi stroke chime did not repeat");
  req_gate_a: assert property (
    !req_ff && !chime_set |=> !chime_relay_contact_o)
    else $error("relay closed without a chime request");
  silence_irq_a: assert property (
    silence && req_ff |=> irq_ff[IRQ_SIL_POS])
    else $error("silence event not recorded");

  incoming_c: cover property ((|ev_in) ##[1:20] chime_relay_contact_o);
  answer_c: cover property (alert_ff[0] ##[1:20] off_rise[0]);
  multi_c: cover property ((st_ff == CH_GAP) ##[1:100] (st_ff == CH_ON));
  irq_c: cover property ($rose(irq_o));
  key_c: cover property (ev_key[0] ##1 hook_ff[0]);
endmodule
`default_nettype wire

// *** bench/ccs_cockpit.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccs_cockpit (
  input wire logic clk_i,
  input wire logic [1:0] lamp_i,
  input wire logic chime_i,
  output var ccs_pkg::ccs_in_t pins_o,
  output var int strokes_o,
  output var int flashes_o
);
  import ccs_pkg::*;
  logic [1:0] lamp_ff;
  logic chime_ff;
  // Released switches read high through their pull-ups.
  initial begin
    pins_o = IN_RST;
    strokes_o = 0;
    flashes_o = 0;
    lamp_ff = 2'h0;
    chime_ff = 1'b0;
  end
  // Switch levels move just after a clock edge, like a real contact seen by a sampler.
  task automatic set_pin(input int idx, input logic lvl);
    @(posedge clk_i);
    pins_o[idx] <= lvl;
  endtask
  // Counting strokes and lamp changes lets the bench judge chime and flash modes.
  always @(posedge clk_i) begin
    lamp_ff <= lamp_i;
    chime_ff <= chime_i;
    if (chime_i && !chime_ff) strokes_o <= strokes_o + 1;
    if (lamp_i[0] != lamp_ff[0]) flashes_o <= flashes_o + 1;
  end
endmodule
`default_nettype wire

// *** bench/ccs_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module ccs_top_tb;
  import ccs_pkg::*;
  localparam int STK = 8;
  localparam int GAP = 6;
  localparam int FLS = 5;
  logic clk_i;
  logic resetn_i;
  ccs_addr_t reg_addr_i;
  ccs_data_t reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  ccs_data_t reg_rdata_o;
  ccs_in_t pins_i;
  logic [1:0] call_lamp_out_o;
  logic chime_relay_contact_o;
  logic irq_o;
  int strokes;
  int flashes;
  int bad_count;
  int samples_checked;
  int s0;
  ccs_data_t d;
  ccs_top #(.STROKE_CYC(STK), .GAP_CYC(GAP), .FLASH_CYC(FLS)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pins_i(pins_i),
    .call_lamp_out_o(call_lamp_out_o), .chime_relay_contact_o(chime_relay_contact_o),
    .irq_o(irq_o));
  ccs_cockpit sw (.clk_i(clk_i), .lamp_i(call_lamp_out_o), .chime_i(chime_relay_contact_o),
    .pins_o(pins_i), .strokes_o(strokes), .flashes_o(flashes));
  task automatic end_of_test();
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input ccs_addr_t a, input ccs_data_t v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input ccs_addr_t a);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  // Bounded so a stuck relay ends the run instead of hanging it.
  task automatic wait_relay_open();
    int i;
    i = 0;
    while (chime_relay_contact_o !== 1'b0) begin
      cyc(1);
      i++;
      if (i > 100) begin
        bad_count++;
        end_of_test();
      end
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    resetn_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    cyc(1);
    `CHK("lamps", 2'h0, call_lamp_out_o)
    `CHK("relay", 1'b0, chime_relay_contact_o)
    wr(8'h14, 32'hFF);
    rd(OFS_CTRL);
    `CHK("ctrl", 32'h0, d)
    rd(OFS_IRQ_MASK);
    `CHK("mask", 32'h0, d)
    rd(8'h14);
    `CHK("unmapped", 32'h0, d)
    // Push-to-talk on channel 0: first mic fall takes the call, hang-up fall drops it.
    wr(OFS_IRQ_MASK, 32'h3);
    wr(OFS_CALL, 32'h1);
    cyc(2);
    `CHK("lamp in", 2'h1, call_lamp_out_o)
    `CHK("relay in", 1'b1, chime_relay_contact_o)
    sw.set_pin(0, 1'b0);
    cyc(5);
    `CHK("lamp offhook", 2'h0, call_lamp_out_o)
    `CHK("irq", 1'b1, irq_o)
    rd(OFS_STAT);
    `CHK("hook", 2'h1, d[1:0])
    wr(OFS_IRQ_STAT, 32'h1);
    cyc(1);
    `CHK("irq clr", 1'b0, irq_o)
    sw.set_pin(0, 1'b1);
    sw.set_pin(0, 1'b0);
    cyc(5);
    rd(OFS_STAT);
    `CHK("hook again", 2'h1, d[1:0])
    sw.set_pin(0, 1'b1);
    sw.set_pin(2, 1'b0);
    cyc(5);
    rd(OFS_STAT);
    `CHK("hangup", 2'h0, d[1:0])
    `CHK("irq masked", 1'b0, irq_o)
    sw.set_pin(2, 1'b1);
    // Single stroke on channel 1: one closure, lamp stays on.
    wait_relay_open();
    s0 = strokes;
    wr(OFS_CALL, 32'h2);
    cyc(2 * STK + GAP + 2);
    `CHK("single", 1, strokes - s0)
    `CHK("lamp stays", 2'h2, call_lamp_out_o)
    wr(OFS_CALL, 32'h80);
    cyc(2);
    `CHK("lamp end", 2'h0, call_lamp_out_o)
    // Multi stroke repeats until the silence button.
    wr(OFS_CTRL, 32'h2);
    s0 = strokes;
    wr(OFS_CALL, 32'h1);
    cyc(2 * (STK + GAP) + 4);
    `CHK("multi", 1'b1, strokes - s0 >= 2)
    sw.set_pin(4, 1'b0);
    cyc(5);
    `CHK("silenced", 1'b0, chime_relay_contact_o)
    rd(OFS_STAT);
    `CHK("no offhook", 2'h0, d[1:0])
    sw.set_pin(4, 1'b1);
    // Inhibit hides both lamps and the chime; pending alerts return afterwards.
    sw.set_pin(5, 1'b0);
    wr(OFS_CALL, 32'h2);
    cyc(5);
    `CHK("inh lamps", 2'h0, call_lamp_out_o)
    `CHK("inh relay", 1'b0, chime_relay_contact_o)
    sw.set_pin(5, 1'b1);
    cyc(5);
    `CHK("both lamps", 2'h3, call_lamp_out_o)
    wr(OFS_CALL, 32'hC0);
    cyc(2);
    `CHK("both end", 2'h0, call_lamp_out_o)
    // Outgoing call chimes only when enabled, and only once connected.
    for (int en = 1; en >= 0; en--) begin
      wait_relay_open();
      wr(OFS_CTRL, en);
      wr(OFS_CALL, 32'h8);
      cyc(2);
      `CHK("out lamp", 2'h2, call_lamp_out_o)
      `CHK("out early", 1'b0, chime_relay_contact_o)
      wr(OFS_CALL, 32'h20);
      cyc(2);
      `CHK("out conn", en[0], chime_relay_contact_o)
      wr(OFS_CALL, 32'h80);
    end
    // Latched panel on channel 1 follows the level and ignores hang-up.
    wr(OFS_CTRL, 32'h20);
    sw.set_pin(1, 1'b0);
    sw.set_pin(3, 1'b0);
    cyc(5);
    rd(OFS_STAT);
    `CHK("panel low", 2'h2, d[1:0])
    sw.set_pin(1, 1'b1);
    sw.set_pin(3, 1'b1);
    cyc(5);
    rd(OFS_STAT);
    `CHK("panel high", 2'h0, d[1:0])
    // Flashing lamp, then the line key source.
    wr(OFS_CTRL, 32'h4);
    s0 = flashes;
    wr(OFS_CALL, 32'h1);
    cyc(4 * FLS + 4);
    `CHK("flash", 1'b1, flashes - s0 >= 3)
    wr(OFS_CTRL, 32'h10);
    wr(OFS_CALL, 32'h100);
    cyc(2);
    rd(OFS_STAT);
    `CHK("key hook", 2'h1, d[1:0])
    wr(OFS_CALL, 32'h40);
    cyc(2);
    rd(OFS_STAT);
    `CHK("key end", 2'h0, d[1:0])
    end_of_test();
  end
endmodule
`default_nettype wire
